// ===== pkg/scp_pkg.sv
// Package with register map, field positions and timing constants of the sync control block.
package scp_pkg;
  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h0c;
  localparam logic [7:0] ADDR_DELAY   = 8'h10;
  localparam logic [7:0] ADDR_DIVIDE  = 8'h14;
  localparam logic [7:0] ADDR_STEP    = 8'h18;

  // ****************************************************************
  // Control field positions
  // ****************************************************************
  localparam int CTRL_LINE_POL   = 0;
  localparam int CTRL_FRAME_POL  = 1;
  localparam int CTRL_DHS_PLL    = 2;
  localparam int CTRL_SLICE_DED  = 3;
  localparam int CTRL_SLICE_EN   = 4;
  localparam int CTRL_MIDCLAMP   = 5;
  localparam int CTRL_FMT_LO     = 6;
  localparam int CTRL_WIDTH      = 8;

  // Output format modes select which data buses are used.
  localparam logic [1:0] FMT_OFF  = 2'h0;
  localparam logic [1:0] FMT_A    = 2'h1;
  localparam logic [1:0] FMT_B    = 2'h2;
  localparam logic [1:0] FMT_AB   = 2'h3;

  // Interrupt bits.
  localparam int IRQ_LINE  = 0;
  localparam int IRQ_FRAME = 1;
  localparam int IRQ_LOCK  = 2;
  localparam int IRQ_UNLK  = 3;
  localparam int IRQ_WIDTH = 4;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [CTRL_WIDTH-1:0] CTRL_RST   = 8'h00;
  localparam logic [15:0]           DELAY_RST  = 16'h0004;
  localparam logic [15:0]           DIVIDE_RST = 16'h0320;
  localparam logic [15:0]           STEP_RST   = 16'h0001;
  localparam logic [3:0]            LOCK_CNT   = 4'h8;
  localparam logic [15:0]           LOCK_TOL   = 16'h0002;
  localparam int                    DLY_DEPTH  = 16;
endpackage : scp_pkg

// ===== hdl/scp_pll_core.sv
// Digital PLL core: phase accumulator oscillator, feedback divider and lock detect.
`timescale 1ns/10ps
module scp_pll_core
  import scp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        syncRst,
  input  wire logic        refEdge,
  input  wire logic        hold,
  input  wire logic [15:0] divide,
  input  wire logic [15:0] step,
  output logic             fbPulse,
  output logic             locked
);
  logic [15:0] phaseAcc_r;
  logic [15:0] incr_r;
  logic [15:0] err_r;
  logic [3:0]  goodCnt_r;

  // The feedback divider counts accumulator steps; a pulse ends each line.
  // A reference edge realigns the accumulator, so lock depends on the period
  // match and not on the phase the accumulator happened to start from.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phaseAcc_r <= 16'h0000;
      fbPulse    <= 1'b0;
    end else if (syncRst) begin
      phaseAcc_r <= 16'h0000;
      fbPulse    <= 1'b0;
    end else begin
      fbPulse <= 1'b0;
      if (phaseAcc_r + incr_r >= divide) begin
        phaseAcc_r <= 16'h0000;
        fbPulse    <= 1'b1;
      end else if (refEdge && !hold) begin
        phaseAcc_r <= 16'h0000;
      end else begin
        phaseAcc_r <= phaseAcc_r + incr_r;
      end
    end
  end

  // Phase detector updates only on reference edges and never while held, so
  // the last increment keeps running and frequency stays constant.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      incr_r    <= STEP_RST;
      err_r     <= 16'h0000;
      goodCnt_r <= 4'h0;
      locked    <= 1'b0;
    end else if (syncRst) begin
      incr_r    <= STEP_RST;
      err_r     <= 16'h0000;
      goodCnt_r <= 4'h0;
      locked    <= 1'b0;
    end else if (refEdge && !hold) begin
      err_r  <= phaseAcc_r;
      incr_r <= step;
      if (phaseAcc_r <= LOCK_TOL || phaseAcc_r >= divide - LOCK_TOL) begin
        if (goodCnt_r != LOCK_CNT) goodCnt_r <= goodCnt_r + 4'h1;
        else locked <= 1'b1;
      end else begin
        goodCnt_r <= 4'h0;
        locked    <= 1'b0;
      end
    end
  end

  AST_HOLD_KEEPS_INCR: assert property (@(posedge clk_sys) disable iff (rst)
    hold && !syncRst |=> incr_r == $past(incr_r))
    else $error("Increment changed while hold was high.");
  AST_HOLD_IGNORES_REF: assert property (@(posedge clk_sys) disable iff (rst)
    hold && refEdge && !syncRst |=> err_r == $past(err_r) && locked == $past(locked))
    else $error("Reference edge acted while hold was high.");
endmodule : scp_pll_core

// ===== hdl/scp_sync_ctrl.sv
// Sync, slicer, lock and output-enable control pins with an APB register file.
//
// Function
// - Line sync feeds PLL, polarity programmable.
// - Frame sync polarity is programmable.
// - Display line sync: delayed input or divider.
// - Slicer source selectable, output only when enabled.
// - Dedicated input clamped only inside clamp window.
// - Hold freezes detector, keeps last increment.
// - Bus driven when enable low and used.
// - Clock outputs ignore the output enable.
// - Synchronous active-low reset on master clock.
// - Midlevel clamp on channel 1 floats slicer.
// - Hold makes PLL ignore line sync edges.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module scp_sync_ctrl
  import scp_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        chipReset_n,
  input  wire logic        line_sync_in,
  input  wire logic        frame_sync_in,
  input  wire logic        ext_clamp_window,
  input  wire logic        phase_detector_hold,
  input  wire logic        ch1SliceCmp,
  input  wire logic        dedSliceCmp,
  input  wire logic        outEnable_n,
  input  wire logic        scanEnable,
  output logic             display_line_sync,
  output logic             compSyncOut,
  output logic             compSyncOe,
  output logic             dedClampEn,
  output logic             lockOut,
  output logic             busAOe,
  output logic             busBOe,
  output logic             pixClkOe,
  output logic             irq
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] pinIn;
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  assign pinIn = {scanEnable, outEnable_n, dedSliceCmp, ch1SliceCmp, phase_detector_hold,
                  ext_clamp_window, frame_sync_in, line_sync_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_r[gi] <= 1'b0;
          sync_r[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= pinIn[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  logic lineS, frameS, clampS, holdS, ch1S, dedS, oeNS;
  assign {oeNS, dedS, ch1S, holdS, clampS, frameS, lineS} = sync_r[6:0];
  // Scan enable is sampled but has no effect in functional logic; it must stay low.

  // Chip reset pin: synchronised, then acts only at a clock edge.
  logic rstnMeta_r;
  logic rstnSync_r;
  logic syncRst;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rstnMeta_r <= 1'b0;
      rstnSync_r <= 1'b0;
    end else begin
      rstnMeta_r <= chipReset_n;
      rstnSync_r <= rstnMeta_r;
    end
  end
  assign syncRst = !rstnSync_r;

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [CTRL_WIDTH-1:0] ctrl_r;
  logic [15:0]           delay_r;
  logic [15:0]           divide_r;
  logic [15:0]           step_r;
  logic [IRQ_WIDTH-1:0]  irqSt_r;
  logic [IRQ_WIDTH-1:0]  irqMsk_r;
  logic                  wrAcc;
  logic                  rdAcc;
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && !penable && !pwrite;

  function automatic logic addrOk(input logic [7:0] a);
    addrOk = a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_IRQ_ST || a == ADDR_IRQ_MSK
          || a == ADDR_DELAY || a == ADDR_DIVIDE || a == ADDR_STEP;
  endfunction : addrOk

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_r   <= CTRL_RST;
      delay_r  <= DELAY_RST;
      divide_r <= DIVIDE_RST;
      step_r   <= STEP_RST;
      irqMsk_r <= '0;
    end else if (syncRst) begin
      ctrl_r   <= CTRL_RST;
      delay_r  <= DELAY_RST;
      divide_r <= DIVIDE_RST;
      step_r   <= STEP_RST;
      irqMsk_r <= '0;
    end else if (wrAcc) begin
      case (paddr)
        ADDR_CTRL:    ctrl_r   <= pwdata[CTRL_WIDTH-1:0];
        ADDR_IRQ_MSK: irqMsk_r <= pwdata[IRQ_WIDTH-1:0];
        ADDR_DELAY:   delay_r  <= pwdata[15:0];
        ADDR_DIVIDE:  divide_r <= pwdata[15:0];
        ADDR_STEP:    step_r   <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Answer in the setup cycle so every access completes on its first access edge.
  logic locked;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addrOk(paddr);
      if (rdAcc) begin
        case (paddr)
          ADDR_CTRL:    prdata <= {24'h000000, ctrl_r};
          ADDR_STATUS:  prdata <= {27'h0, oeNS, holdS, frameS, lineS, locked};
          ADDR_IRQ_ST:  prdata <= {28'h0, irqSt_r};
          ADDR_IRQ_MSK: prdata <= {28'h0, irqMsk_r};
          ADDR_DELAY:   prdata <= {16'h0000, delay_r};
          ADDR_DIVIDE:  prdata <= {16'h0000, divide_r};
          ADDR_STEP:    prdata <= {16'h0000, step_r};
          default:      prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Sync polarity and edges
  // ****************************************************************
  logic lineAct, frameAct, lineAct_r, frameAct_r, lineEdge, frameEdge;
  assign lineAct  = lineS ^ ctrl_r[CTRL_LINE_POL];
  assign frameAct = frameS ^ ctrl_r[CTRL_FRAME_POL];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lineAct_r  <= 1'b0;
      frameAct_r <= 1'b0;
    end else begin
      lineAct_r  <= lineAct;
      frameAct_r <= frameAct;
    end
  end
  assign lineEdge  = lineAct && !lineAct_r;
  assign frameEdge = frameAct && !frameAct_r;

  logic fbPulse;
  scp_pll_core u_pll (
    .clk_sys (clk_sys),
    .rst     (rst),
    .syncRst (syncRst),
    .refEdge (lineEdge),
    .hold    (holdS),
    .divide  (divide_r),
    .step    (step_r),
    .fbPulse (fbPulse),
    .locked  (locked)
  );

  // ****************************************************************
  // Display line sync
  // ****************************************************************
  logic [DLY_DEPTH-1:0] dly_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dly_r <= '0;
    end else begin
      dly_r <= {dly_r[DLY_DEPTH-2:0], lineAct};
    end
  end

  logic dhsNxt;
  assign dhsNxt = ctrl_r[CTRL_DHS_PLL] ? fbPulse : dly_r[delay_r[3:0]];

  // ****************************************************************
  // Slicer, lock and output enables
  // ****************************************************************
  logic useA, useB, midClamp, sliceNxt;
  assign midClamp = ctrl_r[CTRL_MIDCLAMP];
  assign sliceNxt = ctrl_r[CTRL_SLICE_DED] ? dedS : ch1S;
  assign useA = ctrl_r[CTRL_FMT_LO +: 2] == FMT_A || ctrl_r[CTRL_FMT_LO +: 2] == FMT_AB;
  assign useB = ctrl_r[CTRL_FMT_LO +: 2] == FMT_B || ctrl_r[CTRL_FMT_LO +: 2] == FMT_AB;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      display_line_sync <= 1'b0;
      compSyncOut       <= 1'b0;
      compSyncOe        <= 1'b0;
      dedClampEn        <= 1'b0;
      lockOut           <= 1'b0;
      busAOe            <= 1'b0;
      busBOe            <= 1'b0;
      pixClkOe          <= 1'b0;
    end else begin
      display_line_sync <= dhsNxt;
      compSyncOut       <= sliceNxt;
      compSyncOe        <= ctrl_r[CTRL_SLICE_EN] && !midClamp;
      dedClampEn        <= ctrl_r[CTRL_SLICE_DED] && clampS;
      lockOut           <= locked;
      busAOe            <= !oeNS && useA;
      busBOe            <= !oeNS && useB;
      pixClkOe          <= 1'b1;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [IRQ_WIDTH-1:0] irqEv;
  logic                 locked_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) locked_r <= 1'b0;
    else locked_r <= locked;
  end
  assign irqEv = {!locked && locked_r, locked && !locked_r, frameEdge, lineEdge};

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqSt_r <= '0;
    end else if (syncRst) begin
      irqSt_r <= '0;
    end else begin
      irqSt_r <= (irqSt_r & ~((wrAcc && paddr == ADDR_IRQ_ST) ? pwdata[IRQ_WIDTH-1:0] : '0))
                 | irqEv;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) irq <= 1'b0;
    else irq <= |(irqSt_r & irqMsk_r);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // A polarity-corrected onset of line sync must reach the PLL as one edge.
  sequence s_line_idle;
    !(lineS ^ ctrl_r[CTRL_LINE_POL]);
  endsequence
  sequence s_line_onset;
    (lineS ^ ctrl_r[CTRL_LINE_POL]) && $stable(ctrl_r[CTRL_LINE_POL]);
  endsequence
  AST_LINE_POL: assert property (@(posedge clk_sys) disable iff (rst)
    s_line_idle ##1 s_line_onset |-> lineEdge)
    else $error("Line sync onset did not reach the PLL.");
  AST_FRAME_POL: assert property (@(posedge clk_sys) disable iff (rst)
    frameEdge |-> frameAct && !$past(frameAct))
    else $error("Frame edge without polarity-corrected rise.");
  AST_DHS_PLL: assert property (@(posedge clk_sys) disable iff (rst)
    ctrl_r[CTRL_DHS_PLL] && fbPulse |=> display_line_sync)
    else $error("Display line sync missed divider pulse.");
  AST_SLICE_EN: assert property (@(posedge clk_sys) disable iff (rst)
    !ctrl_r[CTRL_SLICE_EN] |=> !compSyncOe)
    else $error("Slicer output driven while disabled.");
  AST_DED_CLAMP: assert property (@(posedge clk_sys) disable iff (rst)
    dedClampEn |-> $past(clampS) && $past(ctrl_r[CTRL_SLICE_DED]))
    else $error("Dedicated clamp outside clamp window.");
  AST_MIDCLAMP: assert property (@(posedge clk_sys) disable iff (rst)
    midClamp |=> !compSyncOe)
    else $error("Slicer output driven under midlevel clamp.");
  AST_BUS_OE: assert property (@(posedge clk_sys) disable iff (rst)
    oeNS |=> !busAOe && !busBOe)
    else $error("Data bus driven with enable high.");
  AST_CLK_OE: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(oeNS) |=> ##1 pixClkOe)
    else $error("Clock output dropped with enable.");
  AST_SYNC_RST: assert property (@(posedge clk_sys) disable iff (rst)
    syncRst |=> ctrl_r == CTRL_RST && irqSt_r == '0)
    else $error("Synchronous reset did not clear state.");
  AST_LOCK_OUT: assert property (@(posedge clk_sys) disable iff (rst)
    lockOut == $past(locked))
    else $error("Lock output does not follow lock state.");
endmodule : scp_sync_ctrl

// ===== tb/scp_video_src.sv
// Video source model that drives line sync, frame sync and the clamp window.
`timescale 1ns/10ps
module scp_video_src (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [7:0] period,
  input  wire logic       actLow,
  input  wire logic       winHold,
  output logic            lineSync,
  output logic            frameSync,
  output logic            clampWin
);
  // ****************************************************************
  // Line timing
  // ****************************************************************
  logic [7:0] cnt_r;
  logic [1:0] line_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r  <= 8'h00;
      line_r <= 2'h0;
    end else if (!run || cnt_r >= period - 8'h01) begin
      cnt_r  <= 8'h00;
      line_r <= line_r + 2'h1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // Pulses last four cycles so that the input synchronisers cannot miss them.
  assign lineSync  = actLow ^ (run && cnt_r < 8'h04);
  assign frameSync = actLow ^ (run && cnt_r < 8'h04 && line_r == 2'h0);
  // The window opens on the back porch, after the sync pulse has ended.
  assign clampWin  = winHold || (run && cnt_r >= 8'h06 && cnt_r < 8'h0a);
endmodule : scp_video_src

// ===== tb/scp_sync_ctrl_tb.sv
// Self-checking testbench of the sync control block with a register model.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module scp_sync_ctrl_tb
  import scp_pkg::*;
;
  // ****************************************************************
  // Signals and model
  // ****************************************************************
  logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, period = 8'h40;
  logic [31:0] pwdata = 32'h0, prdata, r, rnd = 32'hb37f;
  logic        pready, pslverr, e, chipReset_n = 1'b1, lineSync, frameSync, clampWin;
  logic        hold = 1'b0, ch1Cmp = 1'b0, dedCmp = 1'b0, oe_n = 1'b1, run = 1'b0;
  logic        actLow = 1'b0, winHold = 1'b0, dls, csOut, csOe, clampEn, lockOut;
  logic        busAOe, busBOe, pixClkOe, irq;
  int          n_mismatch = 0, comparisons = 0, mdl[7], d[4], n;
  const int    wmask[7] = '{32'hff, 0, 0, 32'hf, 32'hffff, 32'hffff, 32'hffff};

  always #25 clk_sys = ~clk_sys;

  scp_video_src i_scp_video_src (.clk_sys(clk_sys), .rst(rst), .run(run), .period(period),
    .actLow(actLow), .winHold(winHold), .lineSync(lineSync), .frameSync(frameSync),
    .clampWin(clampWin));

  scp_sync_ctrl i_scp_sync_ctrl (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chipReset_n(chipReset_n), .line_sync_in(lineSync),
    .frame_sync_in(frameSync), .ext_clamp_window(clampWin), .phase_detector_hold(hold),
    .ch1SliceCmp(ch1Cmp), .dedSliceCmp(dedCmp), .outEnable_n(oe_n),
    .scanEnable(1'b0),
    .display_line_sync(dls), .compSyncOut(csOut), .compSyncOe(csOe), .dedClampEn(clampEn),
    .lockOut(lockOut), .busAOe(busAOe), .busBOe(busBOe), .pixClkOe(pixClkOe), .irq(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic mreset();
    mdl = '{int'(CTRL_RST), 0, 0, 0, int'(DELAY_RST), int'(DIVIDE_RST), int'(STEP_RST)};
  endtask : mreset

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : cyc

  // Called just after a rising edge; returns one edge after the access completes.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dt;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // An idle cycle keeps the next setup from reassigning psel in this time step.
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt);
    if (a != ADDR_STATUS && a != ADDR_IRQ_ST) mdl[a >> 2] = dt & wmask[a >> 2];
  endtask : wr

  task automatic rdm(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", mdl[a >> 2], r)
  endtask : rdm

  // Cycles from a line sync onset to the display line sync rising.
  task automatic lineDelay(output int k);
    for (k = 0; k < 200 && (lineSync ^ actLow) !== 1'b0; k++) @(posedge clk_sys);
    for (k = 0; k < 200 && (lineSync ^ actLow) !== 1'b1; k++) @(posedge clk_sys);
    for (k = 0; k < 200 && dls !== 1'b1; k++) @(posedge clk_sys);
  endtask : lineDelay

  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin
    cyc(60000);
    n_mismatch++;
    tally_and_finish();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    mreset();
    cyc(4);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int a = 0; a < 7; a++) if (a != 1 && a != 2) rdm(8'(a * 4));
    apb(1'b1, 8'h1c, 32'hffff);
    `CHK("pslverr", 1'b1, e)
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("unmapped", 33'h100000000, {e, r})
    `CHK("pixClkOe", 1'b1, pixClkOe)
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL, 32'(i[1:0]) << CTRL_FMT_LO);
      oe_n <= i[2];
      cyc(6);
      `CHK("busAOe", !i[2] && i[0], busAOe)
      `CHK("busBOe", !i[2] && i[1], busBOe)
      `CHK("pixClkOe", 1'b1, pixClkOe)
    end
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      ch1Cmp  <= rnd[0];
      dedCmp  <= rnd[1];
      winHold <= rnd[2];
      wr(ADDR_CTRL, 32'({i[2], i[1], i[0], 3'h0}));
      cyc(6);
      `CHK("compSyncOe", i[1] && !i[2], csOe)
      `CHK("dedClampEn", i[0] && rnd[2], clampEn)
      if (i[1] && !i[2]) `CHK("compSyncOut", i[0] ? rnd[1] : rnd[0], csOut)
    end
    winHold <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      actLow <= p[0];
      wr(ADDR_CTRL, {30'h0, p[0], p[0]});
      cyc(6);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK("status sync", {p[0], p[0]}, r[2:1])
      run <= 1'b1;
      wr(ADDR_DELAY, 32'h2);
      lineDelay(d[2 * p]);
      wr(ADDR_DELAY, 32'h6);
      lineDelay(d[2 * p + 1]);
      `CHK("delay step", 4, d[2 * p + 1] - d[2 * p])
      run <= 1'b0;
    end
    `CHK("delay polarity", d[0], d[2])
    actLow <= 1'b0;
    wr(ADDR_CTRL, 32'h0);
    run <= 1'b1;
    cyc(300);
    wr(ADDR_IRQ_ST, 32'hf);
    cyc(300);
    `CHK("irq masked", 1'b0, irq)
    apb(1'b0, ADDR_IRQ_ST, 32'h0);
    `CHK("irq status", 2'h3, r[1:0])
    wr(ADDR_IRQ_MSK, 32'h1);
    cyc(3);
    `CHK("irq", 1'b1, irq)
    run <= 1'b0;
    cyc(10);
    wr(ADDR_IRQ_ST, 32'hf);
    cyc(3);
    `CHK("irq cleared", 1'b0, irq)
    wr(ADDR_DIVIDE, 32'h20);
    wr(ADDR_STEP, 32'h1);
    period <= 8'h20;
    run <= 1'b1;
    for (n = 0; n < 3000 && lockOut !== 1'b1; n++) @(posedge clk_sys);
    `CHK("lockOut", 1'b1, lockOut)
    wr(ADDR_CTRL, 32'h1 << CTRL_DHS_PLL);
    lineDelay(n);
    @(posedge clk_sys);
    for (n = 1; n < 200 && dls !== 1'b1; n++) @(posedge clk_sys);
    `CHK("divider period", 32, n)
    hold   <= 1'b1;
    period <= 8'h32;
    cyc(1000);
    `CHK("lock held", 1'b1, lockOut)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("status hold", 2'h3, {r[3], r[0]})
    hold <= 1'b0;
    for (n = 0; n < 3000 && lockOut !== 1'b0; n++) @(posedge clk_sys);
    `CHK("lock lost", 1'b0, lockOut)
    apb(1'b0, ADDR_IRQ_ST, 32'h0);
    `CHK("lock events", 2'h3, r[3:2])
    run <= 1'b0;
    wr(ADDR_CTRL, 32'h5f);
    wr(ADDR_DELAY, 32'h9);
    chipReset_n <= 1'b0;
    cyc(4);
    chipReset_n <= 1'b1;
    cyc(4);
    mreset();
    for (int a = 0; a < 7; a++) if (a != 1 && a != 2) rdm(8'(a * 4));
    tally_and_finish();
  end
endmodule : scp_sync_ctrl_tb
